// ---- cpsc_pkg.sv ----
// Purpose: shared constants for the crosspoint serial configuration block
// Assumes: 8 outputs, 16 inputs, 5-bit route entry per output
// Notes: register map is reached over an ahb-lite slave port
package cpsc_pkg;

    // --------------------------------------------------------------
    // matrix geometry
    // --------------------------------------------------------------
    localparam int N_OUT = 8;          // crosspoint outputs
    localparam int SEL_W = 4;          // input selector width
    localparam int ENTRY_W = 5;        // selector plus off bit
    localparam int OFF_BIT = 4;        // off (high impedance) bit in entry
    localparam int FRAME_BITS = 40;    // full-frame length
    localparam int WORD_BITS = 8;      // single-output word length
    localparam int WORD_LSB = FRAME_BITS - WORD_BITS; // word position in shifter
    localparam int WORD_ADDR_LSB = 0;  // output number field
    localparam int WORD_ADDR_W = 3;
    localparam int WORD_SEL_LSB = 3;   // input selector field
    localparam int WORD_OFF_POS = 7;   // off bit of the word
    localparam int SYNC_W = 7;         // pins passing the synchroniser

    // entry values forced by the level pins
    localparam logic [ENTRY_W-1:0] ENTRY_OFF_ZERO = 5'h10; // input 0, off
    localparam logic [ENTRY_W-1:0] ENTRY_ON_ZERO = 5'h00;  // input 0, on

    // --------------------------------------------------------------
    // ahb-lite register map (byte addresses)
    // --------------------------------------------------------------
    localparam int AW = 8;                              // decoded address bits
    localparam logic [AW-1:0] ADDR_CTRL = 8'h00;        // serial enable, apply
    localparam logic [AW-1:0] ADDR_STATUS = 8'h04;      // live state flags
    localparam logic [AW-1:0] ADDR_ACTIVE_LO = 8'h08;   // active outputs 0..3
    localparam logic [AW-1:0] ADDR_ACTIVE_HI = 8'h0C;   // active outputs 4..7
    localparam logic [AW-1:0] ADDR_STAGE_LO = 8'h10;    // staged outputs 0..3
    localparam logic [AW-1:0] ADDR_STAGE_HI = 8'h14;    // staged outputs 4..7

    // field positions
    localparam int CTRL_EN_BIT = 0;     // serial port enable, reset 1
    localparam int CTRL_APPLY_BIT = 1;  // write 1 to apply staged data
    localparam int ST_ARMED_BIT = 0;
    localparam int ST_DIRTY_BIT = 1;
    localparam int ST_FOFF_BIT = 2;
    localparam int ST_AON_BIT = 3;
    localparam int ST_MODE_BIT = 4;
    localparam int PACK_STRIDE = 8;     // one byte per entry in read words
    localparam int HALF_OUT = 4;        // entries per read word

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HRESP_OKAY = 2'h0;
    localparam logic CTRL_EN_RESET = 1'b1;

endpackage

// ---- cpsc_sync.sv ----
// Purpose: two-flop synchroniser for the serial and level pins
// Assumes: pins are asynchronous to clk_sys_i
// Notes: first stage feeds only the second stage
`timescale 1ns/100ps
module cpsc_sync
    import cpsc_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic srst_i,
    // pins in, synchronised levels out
    input wire logic [SYNC_W-1:0] pin_i,
    output logic [SYNC_W-1:0] sync_o
);

    // --------------------------------------------------------------
    // state
    // --------------------------------------------------------------
    typedef struct packed {
        logic [SYNC_W-1:0] meta;  // first stage, read by second only
        logic [SYNC_W-1:0] sync;  // second stage
    } cpsc_sync_t;

    cpsc_sync_t s_reg;
    cpsc_sync_t s_next;

    // reset value: all pins low (select reads as asserted until its high level passes sync)
    localparam cpsc_sync_t SYNC_RESET = '0;

    // shift through both stages
    always_comb begin
        s_next.meta = pin_i;
        s_next.sync = s_reg.meta;
    end

    // register the copy
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            s_reg <= SYNC_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    assign sync_o = s_reg.sync;

endmodule

// ---- cpsc_serial_config.sv ----
// Purpose: serial configuration logic of a 16x8 analog crosspoint
// Assumes: serial clock is slow enough to be oversampled by clk_sys_i
// Notes: load shifter, staging bank and active bank, plus ahb-lite view
//
// The AHB-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/100ps

module cpsc_serial_config
    import cpsc_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic srst_i,
    // serial configuration pins
    input wire logic sclk_i,
    input wire logic sel_n_i,
    input wire logic sdin_i,
    output logic sdout_o,
    input wire logic mode_i,
    input wire logic apply_i,
    // level override pins
    input wire logic force_off_i,
    input wire logic all_on_input_zero_i,
    // crosspoint matrix control
    output logic [N_OUT*SEL_W-1:0] route_sel_o,
    output logic [N_OUT-1:0] route_off_o,
    // ahb-lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic [1:0] hresp_o
);

    // --------------------------------------------------------------
    // state and types
    // --------------------------------------------------------------
    typedef logic [N_OUT-1:0][ENTRY_W-1:0] cpsc_bank_t;

    typedef struct packed {
        logic sclk_d;                  // previous synced serial clock
        logic apply_d;                 // previous synced apply strobe
        logic armed;                   // select seen low at a rising edge
        logic dirty;                   // staged data not yet applied
        logic serial_en;               // software enable of the serial port
        logic soft_apply;              // one-cycle apply from software
        logic [FRAME_BITS-1:0] sh;     // load shift register
        cpsc_bank_t stage;             // staged configuration
        cpsc_bank_t active;            // configuration driving the matrix
        logic sdout;                   // serial output flop
        logic wr_pend;                 // ahb write in data phase
        logic [AW-1:0] wr_addr;        // address of pending write
        logic [31:0] hrdata;           // read data for data phase
        logic hready;                  // always ready, zero wait states
    } cpsc_state_t;

    // force-off contents at reset so the matrix starts quiet
    localparam cpsc_state_t STATE_RESET = '{
        sclk_d: 1'b0, apply_d: 1'b0, armed: 1'b0, dirty: 1'b0,
        serial_en: CTRL_EN_RESET, soft_apply: 1'b0, sh: '0,
        stage: {N_OUT{ENTRY_OFF_ZERO}}, active: {N_OUT{ENTRY_OFF_ZERO}},
        sdout: 1'b0, wr_pend: 1'b0, wr_addr: '0, hrdata: '0, hready: 1'b1
    };

    cpsc_state_t s_reg;
    cpsc_state_t s_next;

    // synchronised pin levels
    logic [SYNC_W-1:0] pins_s;
    logic sclk_s;
    logic sel_n_s;
    logic sdin_s;
    logic mode_s;
    logic apply_s;
    logic foff_s;
    logic aon_s;

    // event terms for the logic, all but addr_phase also used by checks
    logic sclk_rise;
    logic sclk_fall;
    logic apply_req;
    logic addr_phase;

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    // four entries of a bank, one per byte, for a read word
    function automatic logic [31:0] pack_half(input cpsc_bank_t bank, input logic hi);
        logic [31:0] w;
        w = '0;
        for (int i = 0; i < HALF_OUT; i++) begin
            w[i*PACK_STRIDE +: ENTRY_W] = bank[hi ? i + HALF_OUT : i];
        end
        return w;
    endfunction

    // --------------------------------------------------------------
    // pin synchronisers
    // --------------------------------------------------------------
    cpsc_sync u_sync (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .pin_i({sclk_i, sel_n_i, sdin_i, mode_i, apply_i, force_off_i, all_on_input_zero_i}),
        .sync_o(pins_s)
    );

    assign {sclk_s, sel_n_s, sdin_s, mode_s, apply_s, foff_s, aon_s} = pins_s;

    // edges of the serial clock and the apply strobe
    assign sclk_rise = sclk_s & ~s_reg.sclk_d & s_reg.serial_en;
    assign sclk_fall = ~sclk_s & s_reg.sclk_d & s_reg.serial_en;
    assign apply_req = (apply_s & ~s_reg.apply_d) | s_reg.soft_apply;
    assign addr_phase = hsel_i & (htrans_i == HTRANS_NONSEQ) & hready_i;

    // --------------------------------------------------------------
    // next-state logic
    // --------------------------------------------------------------
    always_comb begin
        logic [WORD_BITS-1:0] word;
        logic [WORD_ADDR_W-1:0] tgt;
        word = s_reg.sh[WORD_LSB +: WORD_BITS];
        tgt = word[WORD_ADDR_LSB +: WORD_ADDR_W];
        s_next = s_reg;
        s_next.sclk_d = sclk_s;
        s_next.apply_d = apply_s;
        s_next.soft_apply = 1'b0;

        // a rising edge with select low arms the shifter
        if (sclk_rise && !sel_n_s) begin
            s_next.armed = 1'b1;
        end else if (sclk_rise && s_reg.armed) begin
            // rise after select high ends the load
            s_next.armed = 1'b0;
            s_next.dirty = 1'b1;
            if (!mode_s) begin
                // frame fills every entry in place
                s_next.stage = s_reg.sh;
            end else begin
                s_next.stage[tgt] = {word[WORD_OFF_POS], word[WORD_SEL_LSB +: SEL_W]};
            end
        end

        // falling edge shifts only while armed and selected
        if (sclk_fall && s_reg.armed && !sel_n_s) begin
            s_next.sh = {sdin_s, s_reg.sh[FRAME_BITS-1:1]};
        end

        // oldest bit leaves on the rise, stable for the next fall
        if (sclk_rise) begin
            s_next.sdout = s_reg.sh[0];
        end

        // apply copies staging only when new data exists
        if (apply_req && s_reg.dirty) begin
            s_next.active = s_next.stage;
            s_next.dirty = 1'b0;
        end

        // all-on level overrides the active bank
        if (aon_s) begin
            s_next.active = {N_OUT{ENTRY_ON_ZERO}};
        end

        // force-off comes last so it wins
        if (foff_s) begin
            s_next.active = {N_OUT{ENTRY_OFF_ZERO}};
            s_next.stage = {N_OUT{ENTRY_OFF_ZERO}};
            s_next.dirty = 1'b0;
        end

        // ahb data phase: writes land here
        s_next.wr_pend = 1'b0;
        if (s_reg.wr_pend && s_reg.wr_addr == ADDR_CTRL) begin
            s_next.serial_en = hwdata_i[CTRL_EN_BIT];
            s_next.soft_apply = hwdata_i[CTRL_APPLY_BIT];
        end

        // ahb address phase: latch writes, fetch reads from fresh values
        if (addr_phase && hwrite_i) begin
            s_next.wr_pend = 1'b1;
            s_next.wr_addr = haddr_i[AW-1:0];
        end
        if (addr_phase && !hwrite_i) begin
            unique case (haddr_i[AW-1:0])
                ADDR_CTRL: begin
                    s_next.hrdata = '0;
                    s_next.hrdata[CTRL_EN_BIT] = s_next.serial_en;
                end
                ADDR_STATUS: begin
                    s_next.hrdata = '0;
                    s_next.hrdata[ST_ARMED_BIT] = s_reg.armed;
                    s_next.hrdata[ST_DIRTY_BIT] = s_reg.dirty;
                    s_next.hrdata[ST_FOFF_BIT] = foff_s;
                    s_next.hrdata[ST_AON_BIT] = aon_s;
                    s_next.hrdata[ST_MODE_BIT] = mode_s;
                end
                ADDR_ACTIVE_LO: s_next.hrdata = pack_half(s_reg.active, 1'b0);
                ADDR_ACTIVE_HI: s_next.hrdata = pack_half(s_reg.active, 1'b1);
                ADDR_STAGE_LO: s_next.hrdata = pack_half(s_reg.stage, 1'b0);
                ADDR_STAGE_HI: s_next.hrdata = pack_half(s_reg.stage, 1'b1);
                // unmapped reads return zero, still okay
                default: s_next.hrdata = '0;
            endcase
        end
    end

    // register the whole state
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            s_reg <= STATE_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // --------------------------------------------------------------
    // outputs straight from flops, hresp_o tied to okay
    // --------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < N_OUT; i++) begin
            route_sel_o[i*SEL_W +: SEL_W] = s_reg.active[i][SEL_W-1:0];
            route_off_o[i] = s_reg.active[i][OFF_BIT];
        end
    end
    assign sdout_o = s_reg.sdout;
    assign hrdata_o = s_reg.hrdata;
    assign hreadyout_o = s_reg.hready;
    assign hresp_o = HRESP_OKAY;

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);

    sequence load_end;
        sclk_rise && sel_n_s && s_reg.armed;
    endsequence

    sequence fresh_apply;
        apply_req && s_reg.dirty && !foff_s && !aon_s;
    endsequence

    chk_force_off_all: assert property (
        foff_s |=> (s_reg.active == {N_OUT{ENTRY_OFF_ZERO}}) && (&route_off_o))
        else $error("force-off did not clear the matrix");

    chk_all_on_zero: assert property (
        aon_s && !foff_s |=> (route_off_o == '0) && (route_sel_o == '0))
        else $error("all-on did not route every output to input 0");

    chk_active_needs_apply: assert property (
        !$stable(s_reg.active) |-> $past(apply_req) || $past(foff_s) || $past(aon_s))
        else $error("active bank changed without apply or override");

    chk_apply_copies: assert property (
        fresh_apply |=> (s_reg.active == s_reg.stage) && !s_reg.dirty)
        else $error("apply did not copy staged data");

    chk_reapply_stable: assert property (
        apply_req && !s_reg.dirty && !foff_s && !aon_s |=> $stable(s_reg.active))
        else $error("repeat apply disturbed the active bank");

    chk_shift_fall: assert property (
        sclk_fall && s_reg.armed && !sel_n_s |=>
        s_reg.sh == {$past(sdin_s), $past(s_reg.sh[FRAME_BITS-1:1])})
        else $error("shifter missed a falling-edge bit");

    chk_sel_high_idle: assert property (
        sel_n_s && !s_reg.armed |=> $stable(s_reg.sh) && !s_reg.armed)
        else $error("shifter moved while select was high");

    chk_frame_commit: assert property (
        load_end and !mode_s and !foff_s |=> s_reg.stage == $past(s_reg.sh) && s_reg.dirty)
        else $error("full frame not staged at load end");

    chk_word_commit: assert property (
        load_end and mode_s and !foff_s |=>
        s_reg.stage[$past(s_reg.sh[WORD_LSB +: WORD_ADDR_W])] ==
        $past(s_reg.sh[FRAME_BITS-1:WORD_LSB+WORD_ADDR_W]))
        else $error("addressed word not staged");

    chk_dout_rise: assert property (
        sclk_rise |=> sdout_o == $past(s_reg.sh[0]) ##1 $stable(sdout_o) [*2])
        else $error("serial output not updated on rise");

endmodule

// ---- cpsc_host_model.sv ----
// Purpose: host model that drives the serial configuration pins
// Assumes: link clock period 64 ns, clock stands low outside frames
// Notes: released data line shows the inverse of its last bit
`timescale 1ns/100ps
module cpsc_host_model (
    // serial pins toward the device
    output logic sclk_o,
    output logic sel_n_o,
    output logic sdin_o,
    // chained output from the device
    input wire logic sdout_i
);
    // --------------------------------------------------------------
    // state
    // --------------------------------------------------------------
    logic [79:0] cap; // sdout level just before each falling edge

    // idle levels at time zero
    initial begin
        sclk_o = 1'b0;
        sel_n_o = 1'b1;
        sdin_o = 1'b0;
        cap = '0;
    end

    // --------------------------------------------------------------
    // frame transfer, bit 0 first
    // --------------------------------------------------------------
    // select kept apart from apply; clock stopped between frames
    task automatic send(input logic [79:0] bits, input int n);
        // select low while clock low, before first rise
        sel_n_o = 1'b0;
        #32;
        for (int i = 0; i < n; i++) begin
            sclk_o = 1'b1;
            sdin_o = bits[i];
            #32;
            cap[i] = sdout_i;
            sclk_o = 1'b0;
            #32;
        end
        // select high at once, then one more rise
        sel_n_o = 1'b1;
        sdin_o = ~sdin_o;
        #32;
        sclk_o = 1'b1;
        #32;
        sclk_o = 1'b0;
        #32;
    endtask

    // clock and data activity with select high; n even leaves clock low
    task automatic noise(input int n);
        for (int i = 0; i < n; i++) begin
            sclk_o = ~sclk_o;
            sdin_o = i[1];
            #32;
        end
    endtask
endmodule

// ---- tb_crosspoint_serial_config.sv ----
// Purpose: self-checking bench for the crosspoint serial configuration
// Assumes: host model on the serial pins, bench as ahb-lite master
// Notes: expected banks are built here from the frame layout
`timescale 1ns/100ps
`define CHK(g, e) \
    begin \
        total_checks++; \
        if ((g) !== (e)) begin \
            num_errors++; \
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, g, e); \
        end \
    end
module tb_crosspoint_serial_config;
    import cpsc_pkg::*;
    // --------------------------------------------------------------
    // signals
    // --------------------------------------------------------------
    typedef struct packed {
        logic m;
        logic [39:0] bits;
        logic [31:0] sel;
        logic [7:0] off;
    } cpsc_row_t; // one load: mode, bits, banks expected after apply
    logic clk_sys_i = 1'b0;
    logic srst_i = 1'b1;
    logic mode_i = 1'b0;
    logic apply_i = 1'b0;
    logic force_off_i = 1'b0;
    logic all_on_input_zero_i = 1'b0;
    logic hsel_i = 1'b0;
    logic hwrite_i = 1'b0;
    logic [31:0] haddr_i = '0;
    logic [31:0] hwdata_i = '0;
    logic [1:0] htrans_i = 2'h0;
    logic [2:0] hsize_i = 3'h2; // word transfers only
    wire sclk, sel_n, sdin, sdout_o, hreadyout_o;
    wire [31:0] route_sel_o, hrdata_o;
    wire [7:0] route_off_o;
    wire [1:0] hresp_o;
    int num_errors = 0;
    int total_checks = 0;
    logic [31:0] rd; // last read word
    logic [39:0] fa, fb; // two frames for the chained transfer
    cpsc_row_t rows [4];

    // free-running system clock, 5 ns
    always #2.5 clk_sys_i = ~clk_sys_i;

    cpsc_serial_config u_dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .sclk_i(sclk),
        .sel_n_i(sel_n), .sdin_i(sdin), .sdout_o(sdout_o), .mode_i(mode_i),
        .apply_i(apply_i), .force_off_i(force_off_i),
        .all_on_input_zero_i(all_on_input_zero_i), .route_sel_o(route_sel_o),
        .route_off_o(route_off_o), .hsel_i(hsel_i), .haddr_i(haddr_i),
        .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
        .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o), .hresp_o(hresp_o));
    cpsc_host_model u_host (.sclk_o(sclk), .sel_n_o(sel_n), .sdin_o(sdin),
        .sdout_i(sdout_o));

    // --------------------------------------------------------------
    // tasks
    // --------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask

    // one single ahb-lite transfer; waits are bounded
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int k;
        @(posedge clk_sys_i);
        hsel_i <= 1'b1;
        haddr_i <= {24'h0, a};
        htrans_i <= HTRANS_NONSEQ;
        hwrite_i <= w;
        k = 0;
        do begin
            @(posedge clk_sys_i);
            k++;
        end while (hreadyout_o !== 1'b1 && k < 16);
        htrans_i <= 2'h0;
        hsel_i <= 1'b0;
        hwdata_i <= wd;
        do begin
            @(posedge clk_sys_i);
            k++;
        end while (hreadyout_o !== 1'b1 && k < 32);
        rd = hrdata_o;
        `CHK(hresp_o, HRESP_OKAY)
        if (k >= 32) begin
            num_errors++;
            end_sim();
        end
    endtask

    // set mode, let it settle, shift, let the commit land
    task automatic load(input logic m, input logic [79:0] b, input int n);
        @(posedge clk_sys_i);
        mode_i <= m;
        cyc(4);
        u_host.send(b, n);
        cyc(6);
    endtask

    // apply raised only once shifting is over
    task automatic apply_pulse();
        @(posedge clk_sys_i);
        apply_i <= 1'b1;
        cyc(4);
        apply_i <= 1'b0;
        cyc(8);
    endtask

    task automatic chk_out(input logic [31:0] s, input logic [7:0] o);
        `CHK(route_sel_o, s)
        `CHK(route_off_o, o)
    endtask

    // output n in bits 5n..5n+4, selector lsb first then off
    function automatic logic [39:0] frame(input logic [31:0] s, input logic [7:0] o);
        logic [39:0] f;
        for (int n = 0; n < N_OUT; n++) begin
            f[5*n +: 4] = s[4*n +: 4];
            f[5*n+4] = o[n];
        end
        return f;
    endfunction

    task automatic end_sim();
        if (num_errors == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial begin
        logic [31:0] ps;
        logic [7:0] po;
        rows[0] = '{1'b0, frame(32'h89ABCDEF, 8'hAA), 32'h89ABCDEF, 8'hAA};
        rows[1] = '{1'b1, 40'h2B, 32'h89AB5DEF, 8'hA2};
        rows[2] = '{1'b1, 40'h87, 32'h09AB5DEF, 8'hA2};
        rows[3] = '{1'b1, 40'hD0, 32'h09AB5DEA, 8'hA3};
        cyc(6);
        srst_i <= 1'b0;
        cyc(4);
        // reset levels: all outputs off on input 0
        chk_out(32'h0, 8'hFF);
        ps = 32'h0;
        po = 8'hFF;
        // table rows: staged data waits for apply, then lands
        for (int i = 0; i < 4; i++) begin
            load(rows[i].m, {40'h0, rows[i].bits}, rows[i].m ? WORD_BITS : FRAME_BITS);
            chk_out(ps, po);
            apply_pulse();
            chk_out(rows[i].sel, rows[i].off);
            ps = rows[i].sel;
            po = rows[i].off;
        end
        // register view of the active bank, unmapped and control words
        ahb(1'b0, ADDR_ACTIVE_LO, 32'h0);
        `CHK(rd, 32'h050D1E1A)
        ahb(1'b0, ADDR_ACTIVE_HI, 32'h0);
        `CHK(rd, 32'h10091A0B)
        ahb(1'b0, 8'h40, 32'h0);
        `CHK(rd, 32'h0)
        ahb(1'b0, ADDR_CTRL, 32'h0);
        `CHK(rd, 32'h1)
        // 80 bits in one go: last frame kept, first one leaves on sdout
        fa = frame(32'h01234567, 8'h0F);
        fb = frame(32'h76543210, 8'hF0);
        load(1'b0, {fb, fa}, 80);
        `CHK(u_host.cap[79:40], fa)
        ahb(1'b0, ADDR_STATUS, 32'h0);
        `CHK(rd[ST_DIRTY_BIT], 1'b1)
        // activity with select high must not disturb the staged frame
        u_host.noise(20);
        cyc(6);
        apply_pulse();
        chk_out(32'h76543210, 8'hF0);
        // level overrides, both together, then repeat apply
        @(posedge clk_sys_i);
        all_on_input_zero_i <= 1'b1;
        cyc(6);
        chk_out(32'h0, 8'h00);
        force_off_i <= 1'b1;
        cyc(6);
        chk_out(32'h0, 8'hFF);
        ahb(1'b0, ADDR_STATUS, 32'h0);
        `CHK(rd, 32'h0000000C)
        force_off_i <= 1'b0;
        cyc(6);
        all_on_input_zero_i <= 1'b0;
        cyc(6);
        chk_out(32'h0, 8'h00);
        apply_pulse();
        chk_out(32'h0, 8'h00);
        // serial port disabled: frame ignored
        ahb(1'b1, ADDR_CTRL, 32'h0);
        load(1'b0, {40'h0, frame(32'hFFFFFFFF, 8'h00)}, FRAME_BITS);
        ahb(1'b1, ADDR_CTRL, 32'h1);
        apply_pulse();
        chk_out(32'h0, 8'h00);
        // apply through the control register
        load(1'b0, {40'h0, frame(32'hFFFFFFFF, 8'h00)}, FRAME_BITS);
        ahb(1'b1, ADDR_CTRL, 32'h3);
        cyc(8);
        chk_out(32'hFFFFFFFF, 8'h00);
        // force-off pulse also drops the staged frame
        load(1'b0, {40'h0, frame(32'h12345678, 8'h00)}, FRAME_BITS);
        @(posedge clk_sys_i);
        force_off_i <= 1'b1;
        cyc(6);
        chk_out(32'h0, 8'hFF);
        force_off_i <= 1'b0;
        cyc(6);
        apply_pulse();
        chk_out(32'h0, 8'hFF);
        ahb(1'b0, ADDR_STAGE_HI, 32'h0);
        `CHK(rd, 32'h10101010)
        end_sim();
    end
endmodule
